// *** include/cfp_pkg.sv ***
// Constants for the flag, stack and power-mode block of the CPU core.
// Assumes one CPU clock and a synchronous active-high reset.
package cfp_pkg;

  // Flag register bit positions
  localparam int FLAG_C  = 0;
  localparam int FLAG_Z  = 1;
  localparam int FLAG_N  = 2;
  localparam int FLAG_I0 = 3;
  localparam int FLAG_H  = 4;
  localparam int FLAG_I1 = 5;
  // Value after reset; undefined bits taken as 0, bits 7:6 read as 1
  localparam logic [7:0] FLAGS_RST  = 8'hE8;
  localparam logic [7:0] FLAGS_ONES = 8'hC0;

  // Software priority codes {hi, lo}
  localparam logic [1:0] PRIO_L0 = 2'h2;
  localparam logic [1:0] PRIO_L1 = 2'h1;
  localparam logic [1:0] PRIO_L2 = 2'h0;
  localparam logic [1:0] PRIO_L3 = 2'h3;

  // Stack pointer
  localparam logic [15:0] SP_RST = 16'h01FF;
  localparam logic [7:0]  SP_HI  = 8'h01;
  localparam logic [7:0]  SP_TOP = 8'hFF;
  localparam logic [2:0]  CTX_BYTES  = 3'h5;
  localparam logic [2:0]  CALL_BYTES = 3'h2;

  // ALU operation classes
  localparam logic [3:0] ALU_NONE  = 4'h0;
  localparam logic [3:0] ALU_ADD   = 4'h1;
  localparam logic [3:0] ALU_ADC   = 4'h2;
  localparam logic [3:0] ALU_SUB   = 4'h3;
  localparam logic [3:0] ALU_LOGIC = 4'h4;
  localparam logic [3:0] ALU_SHIFT = 4'h5;
  localparam logic [3:0] ALU_SCF   = 4'h6;
  localparam logic [3:0] ALU_RCF   = 4'h7;
  localparam logic [3:0] ALU_BTJ   = 4'h8;

  // Power sequencing
  localparam logic [7:0]  HALT_OPCODE = 8'h8E;
  localparam int          IRQ_W       = 12;
  localparam logic [11:0] WAKE_MASK   = 12'h3F4;
  localparam int          STAB_CYCLES = 512;
  localparam logic [9:0]  STAB_LAST   = 10'(STAB_CYCLES - 1);

  // Power states
  typedef enum logic [2:0] {
    PWR_BOOT = 3'h0,
    PWR_RUN  = 3'h1,
    PWR_WAIT = 3'h2,
    PWR_HALT = 3'h3,
    PWR_STAB = 3'h4,
    PWR_LOCK = 3'h5
  } cfp_pwr_t;

endpackage

// *** logic/cfp_stack_ram.sv ***
// Stack memory: 256 bytes, one write port, registered read data.
// Assumes the owner sequences pushes and pops one byte per cycle.
`timescale 1ns/1ps
module cfp_stack_ram (
  // Clock
  input  wire logic       clock_in,
  input  wire logic       clk_en_in,
  // Write port
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in,
  // Read port
  input  wire logic       rd_en_in,
  input  wire logic [7:0] rd_addr_in,
  output logic      [7:0] rd_data_out
);

  logic [7:0] mem_q [0:255];

  // Byte write
  always_ff @(posedge clock_in) begin
    if (clk_en_in && wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read
  always_ff @(posedge clock_in) begin
    if (clk_en_in && rd_en_in) begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end

endmodule

// *** logic/cfp_core.sv ***
// Flag register, stack pointer and power-mode sequencer of the CPU core.
// Assumes the instruction decoder drives one-cycle strobes per instruction.
`timescale 1ns/1ps
module cfp_core (
  // Clock and reset
  input  wire logic                      clock_in,
  input  wire logic                      rst_in,
  input  wire logic                      clk_en_in,
  // Instruction decode
  input  wire logic                      op_valid_in,
  input  wire logic [7:0]                opcode_in,
  input  wire logic                      wfi_in,
  input  wire logic                      rim_in,
  input  wire logic                      sim_in,
  // ALU
  input  wire logic [3:0]                alu_op_in,
  input  wire logic [7:0]                alu_a_in,
  input  wire logic [7:0]                alu_b_in,
  input  wire logic                      alu_c_in,
  output logic      [7:0]                result_out,
  // Flag register access
  input  wire logic                      cc_wr_in,
  input  wire logic [7:0]                cc_wdata_in,
  output logic      [7:0]                flags_out,
  // Stack
  input  wire logic                      push_in,
  input  wire logic                      pop_in,
  input  wire logic [7:0]                push_data_in,
  input  wire logic                      rsp_in,
  input  wire logic                      sp_wr_in,
  input  wire logic [7:0]                sp_wdata_in,
  input  wire logic                      call_in,
  input  wire logic [15:0]               pc_in,
  input  wire logic [7:0]                x_in,
  input  wire logic [7:0]                acc_in,
  output logic      [7:0]                pop_data_out,
  output logic                           pop_valid_out,
  output logic      [15:0]               sp_out,
  output logic                           stack_busy_out,
  // Interrupts
  input  wire logic [cfp_pkg::IRQ_W-1:0] irq_pending_in,
  input  wire logic                      irq_entry_in,
  input  wire logic [1:0]                irq_prio_cfg_in,
  // Power and clocks
  input  wire logic                      full_power_in,
  input  wire logic                      pll_lock_in,
  output logic                           cpu_run_out,
  output logic                           osc_on_out,
  output logic                           pll_on_out,
  output logic                           periph_clk_en_out,
  output logic                           usb_clk_en_out,
  output logic                           reset_fetch_out,
  output logic                           irq_resume_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]        flags_q;
  logic [7:0]        flags_d;
  logic [7:0]        result_d;
  logic [4:0]        nib;
  logic [8:0]        add9;
  logic [8:0]        sub9;
  logic              cin_add;
  logic [7:0]        sp_lo_q;
  logic [2:0]        cnt_q;
  logic [39:0]       ctx_q;
  logic              busy;
  logic              ctx_start;
  logic              call_start;
  logic              push_go;
  logic              pop_go;
  logic              wr_en;
  logic [7:0]        wr_data;
  logic [7:0]        sp_inc;
  cfp_pkg::cfp_pwr_t pwr_q;
  cfp_pkg::cfp_pwr_t pwr_d;
  logic [9:0]        tmr_q;
  logic              full_q;
  logic              halt_go;
  logic              wfi_go;
  logic              wake_pend;
  logic              boot_done;
  logic              resume_d;

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic

  // Operand sums for flag evaluation
  always_comb begin
    cin_add = (alu_op_in == cfp_pkg::ALU_ADC) && flags_q[cfp_pkg::FLAG_C];
    nib     = {1'b0, alu_a_in[3:0]} + {1'b0, alu_b_in[3:0]} + {4'h0, cin_add};
    add9    = {1'b0, alu_a_in} + {1'b0, alu_b_in} + {8'h00, cin_add};
    sub9    = {1'b0, alu_a_in} - {1'b0, alu_b_in};
  end

  // Power-state decode of instructions
  assign halt_go   = op_valid_in && (opcode_in == cfp_pkg::HALT_OPCODE) && (pwr_q == cfp_pkg::PWR_RUN);
  assign wfi_go    = wfi_in && (pwr_q == cfp_pkg::PWR_RUN);
  assign wake_pend = |(irq_pending_in & cfp_pkg::WAKE_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Flag register

  // Next flags; start from held value
  always_comb begin
    flags_d  = flags_q;
    result_d = result_out;
    if (cc_wr_in) begin
      flags_d = cc_wdata_in | cfp_pkg::FLAGS_ONES;
    end else begin
      unique case (alu_op_in)
        cfp_pkg::ALU_ADD, cfp_pkg::ALU_ADC: begin
          result_d                   = add9[7:0];
          flags_d[cfp_pkg::FLAG_H]   = nib[4];
          flags_d[cfp_pkg::FLAG_N]   = add9[7];
          flags_d[cfp_pkg::FLAG_Z]   = (add9[7:0] == 8'h00);
          flags_d[cfp_pkg::FLAG_C]   = add9[8];
        end
        cfp_pkg::ALU_SUB: begin
          result_d                   = sub9[7:0];
          flags_d[cfp_pkg::FLAG_N]   = sub9[7];
          flags_d[cfp_pkg::FLAG_Z]   = (sub9[7:0] == 8'h00);
          flags_d[cfp_pkg::FLAG_C]   = sub9[8];
        end
        cfp_pkg::ALU_LOGIC: begin
          result_d                   = alu_b_in;
          flags_d[cfp_pkg::FLAG_N]   = alu_b_in[7];
          flags_d[cfp_pkg::FLAG_Z]   = (alu_b_in == 8'h00);
        end
        cfp_pkg::ALU_SHIFT: begin
          result_d                   = alu_b_in;
          flags_d[cfp_pkg::FLAG_N]   = alu_b_in[7];
          flags_d[cfp_pkg::FLAG_Z]   = (alu_b_in == 8'h00);
          flags_d[cfp_pkg::FLAG_C]   = alu_c_in;
        end
        cfp_pkg::ALU_SCF: flags_d[cfp_pkg::FLAG_C] = 1'b1;
        cfp_pkg::ALU_RCF: flags_d[cfp_pkg::FLAG_C] = 1'b0;
        cfp_pkg::ALU_BTJ: flags_d[cfp_pkg::FLAG_C] = alu_c_in;
        default: begin
          flags_d = flags_q;
        end
      endcase
    end
    // Priority bits: entry load wins over software changes
    if (irq_entry_in) begin
      {flags_d[cfp_pkg::FLAG_I1], flags_d[cfp_pkg::FLAG_I0]} = irq_prio_cfg_in;
    end else if (wfi_go || halt_go || (pwr_q == cfp_pkg::PWR_WAIT)) begin
      {flags_d[cfp_pkg::FLAG_I1], flags_d[cfp_pkg::FLAG_I0]} = cfp_pkg::PRIO_L2;
    end else if (sim_in) begin
      {flags_d[cfp_pkg::FLAG_I1], flags_d[cfp_pkg::FLAG_I0]} = cfp_pkg::PRIO_L3;
    end else if (rim_in) begin
      {flags_d[cfp_pkg::FLAG_I1], flags_d[cfp_pkg::FLAG_I0]} = cfp_pkg::PRIO_L0;
    end
  end

  // Flag and result registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      flags_q    <= cfp_pkg::FLAGS_RST;
      result_out <= 8'h00;
    end else if (clk_en_in) begin
      flags_q    <= flags_d;
      result_out <= result_d;
    end
  end

  assign flags_out = flags_q;

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer and context save

  // Core stack requests; ignored while a save is running
  assign busy       = (cnt_q != 3'h0);
  assign ctx_start  = irq_entry_in && !busy;
  assign call_start = call_in && !busy && !irq_entry_in;
  assign push_go    = push_in && !busy && !ctx_start && !call_start && !rsp_in && !sp_wr_in;
  assign pop_go     = pop_in && !busy && !ctx_start && !call_start && !rsp_in && !sp_wr_in && !push_in;
  assign sp_inc     = sp_lo_q + 8'h01;
  assign wr_en      = busy || push_go;
  assign wr_data    = busy ? ctx_q[7:0] : push_data_in;

  // Low byte of pointer; high byte is fixed
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sp_lo_q <= cfp_pkg::SP_RST[7:0];
    end else if (clk_en_in) begin
      if (busy || push_go) begin
        sp_lo_q <= sp_lo_q - 8'h01;
      end else if (rsp_in) begin
        sp_lo_q <= cfp_pkg::SP_TOP;
      end else if (sp_wr_in) begin
        sp_lo_q <= sp_wdata_in;
      end else if (pop_go) begin
        sp_lo_q <= sp_inc;
      end
    end
  end

  // Save sequencer; PC low byte goes out first
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cnt_q <= 3'h0;
      ctx_q <= 40'h00_0000_0000;
    end else if (clk_en_in) begin
      if (ctx_start) begin
        cnt_q <= cfp_pkg::CTX_BYTES;
        ctx_q <= {flags_q, acc_in, x_in, pc_in[15:8], pc_in[7:0]};
      end else if (call_start) begin
        cnt_q <= cfp_pkg::CALL_BYTES;
        ctx_q <= {24'h00_0000, pc_in[15:8], pc_in[7:0]};
      end else if (busy) begin
        cnt_q <= cnt_q - 3'h1;
        ctx_q <= {8'h00, ctx_q[39:8]};
      end
    end
  end

  // Status outputs of the stack
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      stack_busy_out <= 1'b0;
      pop_valid_out  <= 1'b0;
    end else if (clk_en_in) begin
      stack_busy_out <= ctx_start || call_start || (cnt_q > 3'h1);
      pop_valid_out  <= pop_go;
    end
  end

  assign sp_out = {cfp_pkg::SP_HI, sp_lo_q};

  // Stack storage
  cfp_stack_ram u_ram (
    .clock_in    (clock_in),
    .clk_en_in   (clk_en_in),
    .wr_en_in    (wr_en),
    .wr_addr_in  (sp_lo_q),
    .wr_data_in  (wr_data),
    .rd_en_in    (pop_go),
    .rd_addr_in  (sp_inc),
    .rd_data_out (pop_data_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power-mode sequencer

  assign boot_done = (tmr_q == cfp_pkg::STAB_LAST);

  // Next power state
  always_comb begin
    pwr_d    = pwr_q;
    resume_d = 1'b0;
    unique case (pwr_q)
      cfp_pkg::PWR_BOOT: begin
        if (boot_done) begin
          pwr_d = cfp_pkg::PWR_RUN;
        end
      end
      cfp_pkg::PWR_RUN: begin
        if (halt_go) begin
          if (wake_pend) begin
            resume_d = 1'b1;
          end else begin
            pwr_d = cfp_pkg::PWR_HALT;
          end
        end else if (wfi_go) begin
          pwr_d = cfp_pkg::PWR_WAIT;
        end
      end
      cfp_pkg::PWR_WAIT: begin
        if (|irq_pending_in) begin
          pwr_d    = cfp_pkg::PWR_RUN;
          resume_d = 1'b1;
        end
      end
      cfp_pkg::PWR_HALT: begin
        if (wake_pend) begin
          pwr_d = cfp_pkg::PWR_STAB;
        end
      end
      cfp_pkg::PWR_STAB: begin
        if (boot_done) begin
          pwr_d    = full_q ? cfp_pkg::PWR_LOCK : cfp_pkg::PWR_RUN;
          resume_d = !full_q;
        end
      end
      cfp_pkg::PWR_LOCK: begin
        if (pll_lock_in) begin
          pwr_d    = cfp_pkg::PWR_RUN;
          resume_d = 1'b1;
        end
      end
      default: begin
        pwr_d = cfp_pkg::PWR_BOOT;
      end
    endcase
  end

  // State and stabilisation timer
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pwr_q <= cfp_pkg::PWR_BOOT;
      tmr_q <= 10'h000;
    end else if (clk_en_in) begin
      pwr_q <= pwr_d;
      tmr_q <= (pwr_d != pwr_q) ? 10'h000 : 10'(tmr_q + 10'h001);
    end
  end

  // Mode choice; low power after reset, held across halt
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      full_q <= 1'b0;
    end else if (clk_en_in && (pwr_q == cfp_pkg::PWR_RUN) && !halt_go) begin
      full_q <= full_power_in;
    end
  end

  // Registered clock controls and wake pulses
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cpu_run_out       <= 1'b0;
      osc_on_out        <= 1'b1;
      pll_on_out        <= 1'b0;
      periph_clk_en_out <= 1'b0;
      usb_clk_en_out    <= 1'b0;
      reset_fetch_out   <= 1'b0;
      irq_resume_out    <= 1'b0;
    end else if (clk_en_in) begin
      cpu_run_out       <= (pwr_d == cfp_pkg::PWR_RUN);
      osc_on_out        <= (pwr_d != cfp_pkg::PWR_HALT);
      pll_on_out        <= full_q && ((pwr_d == cfp_pkg::PWR_RUN) || (pwr_d == cfp_pkg::PWR_WAIT) ||
                                      (pwr_d == cfp_pkg::PWR_LOCK));
      periph_clk_en_out <= (pwr_d == cfp_pkg::PWR_RUN) || (pwr_d == cfp_pkg::PWR_WAIT);
      usb_clk_en_out    <= full_q && pll_lock_in &&
                           ((pwr_d == cfp_pkg::PWR_RUN) || (pwr_d == cfp_pkg::PWR_WAIT));
      reset_fetch_out   <= (pwr_q == cfp_pkg::PWR_BOOT) && boot_done;
      irq_resume_out    <= resume_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence stab_end_s;
    (pwr_q == cfp_pkg::PWR_STAB) && (tmr_q == cfp_pkg::STAB_LAST) && !full_q;
  endsequence

  sequence ctx_walk_s;
    stack_busy_out [*5] ##1 !stack_busy_out;
  endsequence

  half_carry_a: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (!cc_wr_in && (alu_op_in == cfp_pkg::ALU_ADD)) |=> (flags_q[cfp_pkg::FLAG_H] == $past(nib[4])))
    else $error("half carry wrong after add");

  neg_copy_a: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (!cc_wr_in && (alu_op_in == cfp_pkg::ALU_LOGIC)) |=> (flags_q[cfp_pkg::FLAG_N] == $past(alu_b_in[7])))
    else $error("negative flag not result msb");

  zero_flag_a: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (!cc_wr_in && (alu_op_in == cfp_pkg::ALU_SUB)) |=> (flags_q[cfp_pkg::FLAG_Z] == (result_out == 8'h00)))
    else $error("zero flag disagrees with result");

  carry_force_a: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (!cc_wr_in && (alu_op_in == cfp_pkg::ALU_SCF)) |=> flags_q[cfp_pkg::FLAG_C])
    else $error("set carry did not set carry");

  prio_load_a: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    irq_entry_in |=> ({flags_q[cfp_pkg::FLAG_I1], flags_q[cfp_pkg::FLAG_I0]} == $past(irq_prio_cfg_in)))
    else $error("priority bits not loaded on entry");

  push_dec_a: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    push_go |=> (sp_lo_q == 8'($past(sp_lo_q) - 8'h01)))
    else $error("push did not decrement pointer");

  ctx_five_a: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    ctx_start |=> ctx_walk_s)
    else $error("context save not five bytes");

  wait_prio_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (pwr_q == cfp_pkg::PWR_WAIT) |-> ({flags_q[cfp_pkg::FLAG_I1], flags_q[cfp_pkg::FLAG_I0]} == 2'h0))
    else $error("priority bits not zero in wait");

  halt_hold_a: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    ((pwr_q == cfp_pkg::PWR_HALT) && !wake_pend) |=> ((pwr_q == cfp_pkg::PWR_HALT) && !osc_on_out))
    else $error("halt left without wake source");

  boot_delay_a: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(reset_fetch_out) |-> ($past(tmr_q) == cfp_pkg::STAB_LAST))
    else $error("reset vector fetched before delay");

  stab_resume_a: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    stab_end_s |=> ((pwr_q == cfp_pkg::PWR_RUN) && irq_resume_out))
    else $error("low power wake did not resume");

  halt_code_a: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (halt_go && !wake_pend) |=> ((pwr_q == cfp_pkg::PWR_HALT) && !cpu_run_out))
    else $error("halt opcode did not halt");

endmodule

// *** verification/cfp_core_tb.sv ***
// Self-checking bench for the flag, stack and power-mode block.
// Assumes cfp_core alone, inputs driven at falling edges, clock enable high except for one two-cycle flag-hold check.
`timescale 1ns/1ps
module testbench;
  ////////////////////////////////////////////////////////////
  // Design signals
  logic        clock_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1;
  logic        op_valid_in, wfi_in, rim_in, sim_in, alu_c_in, cc_wr_in, push_in, pop_in;
  logic        rsp_in, sp_wr_in, call_in, irq_entry_in, full_power_in, pll_lock_in;
  logic [7:0]  opcode_in, alu_a_in, alu_b_in, cc_wdata_in, push_data_in, sp_wdata_in, x_in, acc_in;
  logic [3:0]  alu_op_in;
  logic [1:0]  irq_prio_cfg_in;
  logic [15:0] pc_in, sp_out;
  logic [11:0] irq_pending_in;
  logic [7:0]  result_out, flags_out, pop_data_out;
  logic        pop_valid_out, stack_busy_out, cpu_run_out, osc_on_out, pll_on_out, periph_clk_en_out;
  logic        usb_clk_en_out, reset_fetch_out, irq_resume_out;
  // Model state and counters
  logic [7:0]  fl, lf = 8'h5E;
  logic [7:0]  mem_m [256];
  logic [3:0]  ops [8] = '{cfp_pkg::ALU_ADD, cfp_pkg::ALU_ADC, cfp_pkg::ALU_SUB, cfp_pkg::ALU_LOGIC,
                           cfp_pkg::ALU_SHIFT, cfp_pkg::ALU_SCF, cfp_pkg::ALU_RCF, cfp_pkg::ALU_BTJ};
  int          spm, n, fail_count = 0, checks_done = 0;

  cfp_core uut (.clock_in, .rst_in, .clk_en_in, .op_valid_in, .opcode_in, .wfi_in, .rim_in, .sim_in,
    .alu_op_in, .alu_a_in, .alu_b_in, .alu_c_in, .result_out, .cc_wr_in, .cc_wdata_in, .flags_out,
    .push_in, .pop_in, .push_data_in, .rsp_in, .sp_wr_in, .sp_wdata_in, .call_in, .pc_in, .x_in, .acc_in,
    .pop_data_out, .pop_valid_out, .sp_out, .stack_busy_out, .irq_pending_in, .irq_entry_in,
    .irq_prio_cfg_in, .full_power_in, .pll_lock_in, .cpu_run_out, .osc_on_out, .pll_on_out,
    .periph_clk_en_out, .usb_clk_en_out, .reset_fetch_out, .irq_resume_out);

  // Clock
  always #4 clock_in = ~clock_in;

  ////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tick();
    @(negedge clock_in);
  endtask
  // One-cycle strobe: 0 rsp,1 sp_wr,2 call,3 irq_entry,4 wfi,5 sim,6 rim,7 op_valid,8 cc_wr
  task automatic strobe(input int k);
    tick();
    {rsp_in, sp_wr_in, call_in, irq_entry_in, wfi_in, sim_in, rim_in, op_valid_in, cc_wr_in} = 9'h100 >> k;
    tick();
    {rsp_in, sp_wr_in, call_in, irq_entry_in, wfi_in, sim_in, rim_in, op_valid_in, cc_wr_in} = '0;
  endtask
  // Bounded wait: 0 resume pulse, 1 reset fetch pulse, 2 stack idle
  task automatic wait_ev(input int sel, input int lim);
    n = 0;
    while (n < lim && !((sel == 2) ? stack_busy_out === 1'b0 : (sel ? reset_fetch_out : irq_resume_out) === 1'b1)) begin
      tick();
      n++;
    end
  endtask
  task automatic mpush(input logic [7:0] d);
    mem_m[spm] = d;
    spm = (spm - 1) & 255;
  endtask
  task automatic push(input logic [7:0] d);
    tick();
    {push_in, push_data_in} = {1'b1, d};
    tick();
    push_in = 1'b0;
    mpush(d);
    chk(sp_out, {8'h01, spm[7:0]});
  endtask
  task automatic pop();
    tick();
    pop_in = 1'b1;
    tick();
    pop_in = 1'b0;
    spm = (spm + 1) & 255;
    chk({pop_valid_out, pop_data_out}, {1'b1, mem_m[spm]});
    chk(sp_out, {8'h01, spm[7:0]});
  endtask
  task automatic alu(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b, input logic c);
    int cin;
    int r;
    cin = (op == cfp_pkg::ALU_ADC) ? fl[0] : 0;
    if (op == cfp_pkg::ALU_LOGIC || op == cfp_pkg::ALU_SHIFT) r = b;
    else if (op == cfp_pkg::ALU_SUB) r = a - b;
    else r = a + b + cin;
    tick();
    {alu_op_in, alu_a_in, alu_b_in, alu_c_in} = {op, a, b, c};
    tick();
    alu_op_in = cfp_pkg::ALU_NONE;
    if (op == cfp_pkg::ALU_SCF || op == cfp_pkg::ALU_RCF || op == cfp_pkg::ALU_BTJ) begin
      fl[0] = (op == cfp_pkg::ALU_SCF) || ((op == cfp_pkg::ALU_BTJ) && c);
    end else begin
      fl[2] = r[7];
      fl[1] = (r[7:0] == 0);
      if (op == cfp_pkg::ALU_ADD || op == cfp_pkg::ALU_ADC) fl[4] = ((a & 15) + (b & 15) + cin) > 15;
      // Shift takes carry from the shifter, subtract borrows out of bit 8
      if (op == cfp_pkg::ALU_SHIFT) fl[0] = c;
      else if (op != cfp_pkg::ALU_LOGIC) fl[0] = r[8];
      chk(result_out, r[7:0]);
    end
    chk(flags_out, fl);
  endtask
  task automatic do_reset();
    rst_in = 1'b1;
    repeat (4) tick();
    rst_in = 1'b0;
    fl = 8'hE8;
    spm = 255;
    chk(flags_out, fl);
    chk(sp_out, 16'h01FF);
    wait_ev(1, 600);
    chk(n, 512);
    chk({cpu_run_out, osc_on_out, pll_on_out, periph_clk_en_out, usb_clk_en_out}, 5'b11010);
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #400000;
    fail_count++;
    results();
  end

  // Main sequence
  initial begin
    {op_valid_in, wfi_in, rim_in, sim_in, alu_c_in, cc_wr_in, push_in, pop_in, rsp_in, sp_wr_in} = '0;
    {call_in, irq_entry_in, full_power_in, pll_lock_in, irq_pending_in, irq_prio_cfg_in, pc_in} = '0;
    {opcode_in, alu_a_in, alu_b_in, cc_wdata_in, push_data_in, sp_wdata_in, x_in, acc_in, alu_op_in} = '0;
    do_reset();
    // Flags: boundary sums then random operands over every op class
    alu(cfp_pkg::ALU_ADD, 8'h0F, 8'h01, 1'b0);
    alu(cfp_pkg::ALU_ADD, 8'hFF, 8'h01, 1'b0);
    alu(cfp_pkg::ALU_ADC, 8'h7F, 8'h00, 1'b0);
    alu(cfp_pkg::ALU_SUB, 8'h01, 8'h02, 1'b0);
    for (int i = 0; i < 32; i++) begin
      lf = lfsr(lf);
      alu(ops[i % 8], lf, lfsr(lf), lf[4]);
      lf = lfsr(lf);
    end
    // Clock enable low: a carry change offered meanwhile must not land
    tick();
    {clk_en_in, alu_op_in} = {1'b0, fl[0] ? cfp_pkg::ALU_RCF : cfp_pkg::ALU_SCF};
    repeat (2) tick();
    {clk_en_in, alu_op_in} = {1'b1, cfp_pkg::ALU_NONE};
    chk(flags_out, fl);
    lf = lfsr(lf);
    cc_wdata_in = lf;
    strobe(8);
    fl = lf | 8'hC0;
    chk(flags_out, fl);
    strobe(5);
    {fl[5], fl[3]} = 2'b11;
    chk(flags_out, fl);
    strobe(6);
    {fl[5], fl[3]} = 2'b10;
    chk(flags_out, fl);
    // Stack order, direct load, wrap and stack reset
    for (int i = 0; i < 3; i++) push(8'hA0 + 8'(i));
    repeat (3) pop();
    sp_wdata_in = 8'h00;
    strobe(1);
    spm = 0;
    chk(sp_out, 16'h0100);
    push(8'h5A);
    pop();
    strobe(0);
    spm = 255;
    chk(sp_out, 16'h01FF);
    // Interrupt context save for every priority code, then unstack
    for (int k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      {pc_in, x_in, acc_in, irq_prio_cfg_in} = {lf, ~lf, lf ^ 8'h3C, lf + 8'h01, 2'(k)};
      strobe(3);
      wait_ev(2, 10);
      mpush(pc_in[7:0]);
      mpush(pc_in[15:8]);
      mpush(x_in);
      mpush(acc_in);
      mpush(fl);
      {fl[5], fl[3]} = 2'(k);
      chk(flags_out, fl);
      chk(sp_out, {8'h01, spm[7:0]});
      repeat (5) pop();
    end
    // Subroutine call
    pc_in = {lf, 8'hC3};
    strobe(2);
    repeat (3) tick();
    mpush(pc_in[7:0]);
    mpush(pc_in[15:8]);
    chk(sp_out, {8'h01, spm[7:0]});
    repeat (2) pop();
    // Wait mode, woken by a source that cannot end halt
    strobe(4);
    {fl[5], fl[3]} = 2'b00;
    chk({cpu_run_out, periph_clk_en_out, flags_out}, {2'b01, fl});
    irq_pending_in = 12'h800;
    wait_ev(0, 20);
    chk({irq_resume_out, flags_out}, {1'b1, fl});
    // Halt with a wake source already pending, and a neighbouring opcode
    irq_pending_in = 12'h004;
    opcode_in = cfp_pkg::HALT_OPCODE;
    strobe(7);
    wait_ev(0, 4);
    chk({irq_resume_out, osc_on_out}, 2'b11);
    irq_pending_in = 12'h000;
    opcode_in = 8'h8F;
    strobe(7);
    chk(osc_on_out, 1'b1);
    // Halt entry and interrupt wake from low and full power
    for (int fp = 0; fp < 2; fp++) begin
      tick();
      full_power_in = fp[0];
      opcode_in = cfp_pkg::HALT_OPCODE;
      strobe(7);
      chk({cpu_run_out, osc_on_out, periph_clk_en_out, usb_clk_en_out, flags_out}, {4'h0, fl});
      irq_pending_in = 12'hC0B;
      wait_ev(0, 40);
      chk({irq_resume_out, cpu_run_out, osc_on_out}, 3'h0);
      irq_pending_in = 12'h010;
      wait_ev(0, fp ? 600 : 520);
      if (fp) begin
        chk({irq_resume_out, cpu_run_out, osc_on_out}, 3'h1);
        pll_lock_in = 1'b1;
        wait_ev(0, 8);
      end
      else chk(n, 513);
      chk({irq_resume_out, cpu_run_out, osc_on_out}, 3'h7);
      chk({pll_on_out, usb_clk_en_out}, {2{fp[0]}});
      {irq_pending_in, full_power_in, pll_lock_in} = '0;
    end
    // Reset as the wake event from halt
    opcode_in = cfp_pkg::HALT_OPCODE;
    strobe(7);
    chk(osc_on_out, 1'b0);
    do_reset();
    results();
  end
endmodule
